// *** rtl/hot_swap_fault_supervisor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hsfs_defs.svh"

// Behaviour
// R1 - Undervoltage counts as fault only after low input persists beyond 1.0 ms.
// R2 - Qualified undervoltage turns the pass gate off and drops both power-good outputs.
// R3 - After undervoltage, stay off until input is good beyond 1.0 ms, then restart.
// R4 - A fault during the start-up timer abandons that attempt without gate turn-on.
// R5 - Gate turns on only after faults stay clear for the full start-up time.
// R6 - Overvoltage beyond 1.0 ms is a fault: gate off, power-good outputs off.
// R7 - After overvoltage, stay off until input is normal beyond 1.0 ms, then restart.
// R8 - Over-temperature during start-up or operation turns gate and power-good off.
// R9 - After thermal shutdown no start-up begins until the recovery indication appears.
// R10 - Over-temperature is qualified by a 12 us filter, much shorter than supply filters.
// R11 - The 200 ms start-up timer is reused for every start and every retry.
// R12 - Thermal or disable events restart the timer and count retries; stop beyond 10.
// R13 - Power-good asserts 20 ms after the pass transistor is fully enhanced.
// R14 - Each filter count restarts from zero when its raw indication drops early.
// R15 - Raw comparator indications are synchronised before reaching the filters.
module hot_swap_fault_supervisor
  import hsfs_pkg::*;
#(
  parameter int unsigned SUPPLY_FILT_CYC = `HSFS_SUPPLY_FILT_CYC,
  parameter int unsigned THERM_FILT_CYC = `HSFS_THERM_FILT_CYC,
  parameter int unsigned START_CYC = `HSFS_START_CYC,
  parameter int unsigned PGOOD_CYC = `HSFS_PGOOD_CYC,
  parameter int unsigned RETRY_LIMIT = `HSFS_RETRY_LIMIT
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic underVoltageRaw,
  input wire logic overVoltageRaw,
  input wire logic overTempRaw,
  input wire logic tempRecoveredRaw,
  input wire logic disableRaw,
  input wire logic fullyEnhanced,
  output logic gateEnable,
  output logic power_good_active_high,
  output logic powerGood_n,
  output logic underVoltageFault,
  output logic overVoltageFault,
  output logic thermalFault,
  output logic retryLocked,
  output logic [3:0] retryCount
);

  // ==========================================================
  // Input synchronisation and fault qualification
  logic uvSync;
  logic ovSync;
  logic otSync;
  logic recSync;
  logic disSync;
  logic uvQual;
  logic ovQual;
  logic otQual;
  logic disQual;
  logic feSync;

  // Comparator outputs are asynchronous to this clock
  hsfs_sync uUvSync (.clock(clock), .reset(reset), .rawIn(underVoltageRaw), .syncOut(uvSync)); // R15
  hsfs_sync uOvSync (.clock(clock), .reset(reset), .rawIn(overVoltageRaw), .syncOut(ovSync)); // R15
  hsfs_sync uOtSync (.clock(clock), .reset(reset), .rawIn(overTempRaw), .syncOut(otSync)); // R15
  hsfs_sync uRecSync (.clock(clock), .reset(reset), .rawIn(tempRecoveredRaw), .syncOut(recSync));
  hsfs_sync uDisSync (.clock(clock), .reset(reset), .rawIn(disableRaw), .syncOut(disSync));
  // Enhancement flag comes from the analog pass device, so it is resynchronised too
  hsfs_sync uFeSync (.clock(clock), .reset(reset), .rawIn(fullyEnhanced), .syncOut(feSync));

  // Same filter times both ways: entering and leaving a supply fault need 1.0 ms
  hsfs_filter #(.LIMIT(SUPPLY_FILT_CYC), .INIT(1'b0)) uUvFilt (
    .clock(clock), .reset(reset), .level(uvSync), .qualified(uvQual)); // R1 R3 R14
  hsfs_filter #(.LIMIT(SUPPLY_FILT_CYC), .INIT(1'b0)) uOvFilt (
    .clock(clock), .reset(reset), .level(ovSync), .qualified(ovQual)); // R6 R7 R14
  hsfs_filter #(.LIMIT(THERM_FILT_CYC), .INIT(1'b0)) uOtFilt (
    .clock(clock), .reset(reset), .level(otSync), .qualified(otQual)); // R10 R14
  hsfs_filter #(.LIMIT(SUPPLY_FILT_CYC), .INIT(1'b0)) uDisFilt (
    .clock(clock), .reset(reset), .level(disSync), .qualified(disQual));

  // ==========================================================
  // Thermal latch: held until the recovery indication is seen
  logic thermLatch;
  logic next_thermLatch;

  always_comb begin
    next_thermLatch = thermLatch;
    if (otQual) begin
      next_thermLatch = 1'b1; // R8
    end else if (recSync) begin
      next_thermLatch = 1'b0; // R9
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      thermLatch <= 1'b0;
    end else begin
      thermLatch <= next_thermLatch;
    end
  end

  // ==========================================================
  // Disable request edge: only reset or a new request may release a lockout
  logic disQualPrev;
  logic next_disQualPrev;
  logic disRise;

  assign disRise = disQual & ~disQualPrev;

  always_comb begin
    next_disQualPrev = disQual;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      disQualPrev <= 1'b0;
    end else begin
      disQualPrev <= next_disQualPrev;
    end
  end

  // ==========================================================
  // Shared timer and retry arithmetic
  function automatic logic timerDone(input logic [31:0] count, input int unsigned limit);
    return count >= limit - 1;
  endfunction

  function automatic logic [31:0] timerStep(input logic [31:0] count);
    return count + 32'h0000_0001;
  endfunction

  // Only thermal and disable aborts are counted
  function automatic logic [3:0] abortRetry(input logic [3:0] count, input logic counted);
    return counted ? count + 4'h1 : count;
  endfunction

  // ==========================================================
  // Sequencer
  hsfs_state_e state;
  hsfs_state_e next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [3:0] next_retryCount;
  logic next_gateEnable;
  logic next_pgood;
  logic supplyBad;
  logic anyFault;
  logic countedFault;

  // Supply faults retry forever; thermal and disable count toward the limit
  assign supplyBad = uvQual | ovQual;
  assign countedFault = thermLatch | otQual | disQual;
  assign anyFault = supplyBad | countedFault;

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_retryCount = retryCount;
    next_gateEnable = 1'b0;
    next_pgood = 1'b0;
    unique case (state)
      HSFS_IDLE: begin
        next_timer = 32'h0000_0000;
        if (!anyFault) begin
          next_state = HSFS_START; // R3 R7 R9
        end
      end
      HSFS_START: begin
        if (anyFault) begin
          next_state = HSFS_FAULT; // R4
          next_timer = 32'h0000_0000;
          next_retryCount = abortRetry(retryCount, countedFault); // R12
        end else if (timerDone(timer, START_CYC)) begin
          next_state = HSFS_CHARGE; // R5 R11
          next_timer = 32'h0000_0000;
          next_gateEnable = 1'b1;
        end else begin
          next_timer = timerStep(timer);
        end
      end
      HSFS_CHARGE: begin
        // Gate held on while the load capacitor charges; timer is already zero here
        if (anyFault) begin
          next_state = HSFS_FAULT; // R2 R6 R8
          next_retryCount = abortRetry(retryCount, countedFault); // R12
        end else begin
          next_gateEnable = 1'b1;
          if (feSync) begin
            next_state = HSFS_PGWAIT; // R13
          end
        end
      end
      HSFS_PGWAIT: begin
        if (anyFault) begin
          next_state = HSFS_FAULT; // R2 R6 R8
          next_timer = 32'h0000_0000;
          next_retryCount = abortRetry(retryCount, countedFault); // R12
        end else begin
          next_gateEnable = 1'b1;
          if (timerDone(timer, PGOOD_CYC)) begin
            // A completed start clears the retry history
            next_state = HSFS_NORMAL; // R13
            next_pgood = 1'b1;
            next_retryCount = `HSFS_RETRY_RST;
            next_timer = 32'h0000_0000;
          end else begin
            next_timer = timerStep(timer);
          end
        end
      end
      HSFS_NORMAL: begin
        if (anyFault) begin
          next_state = HSFS_FAULT; // R2 R6 R8
          next_retryCount = abortRetry(retryCount, countedFault); // R12
        end else begin
          next_gateEnable = 1'b1;
          next_pgood = 1'b1;
        end
      end
      HSFS_FAULT: begin
        // Supply faults retry without limit; counted faults stop past the limit
        next_timer = 32'h0000_0000;
        if (retryCount > RETRY_LIMIT[3:0]) begin
          next_state = HSFS_LOCKED; // R12
        end else if (!anyFault) begin
          next_state = HSFS_START; // R3 R7 R9 R11
        end
      end
      HSFS_LOCKED: begin
        // Reset or a fresh disable request clears the lockout; the request that
        // caused the last abort may still be held and must not release it
        next_timer = 32'h0000_0000;
        if (disRise) begin
          next_retryCount = `HSFS_RETRY_RST; // R12
          next_state = HSFS_IDLE;
        end
      end
      default: begin
        next_state = HSFS_IDLE;
        next_timer = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= HSFS_IDLE;
      timer <= `HSFS_CNT_RST;
      retryCount <= `HSFS_RETRY_RST;
      gateEnable <= 1'b0;
      power_good_active_high <= 1'b0;
      powerGood_n <= 1'b1;
    end else begin
      state <= next_state;
      timer <= next_timer;
      retryCount <= next_retryCount;
      gateEnable <= next_gateEnable;
      power_good_active_high <= next_pgood;
      powerGood_n <= ~next_pgood;
    end
  end

  // ==========================================================
  // Status outputs
  logic next_underVoltageFault;
  logic next_overVoltageFault;
  logic next_thermalFault;
  logic next_retryLocked;

  always_comb begin
    next_underVoltageFault = uvQual;
    next_overVoltageFault = ovQual;
    next_thermalFault = next_thermLatch;
    next_retryLocked = (next_state == HSFS_LOCKED);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      underVoltageFault <= 1'b0;
      overVoltageFault <= 1'b0;
      thermalFault <= 1'b0;
      retryLocked <= 1'b0;
    end else begin
      underVoltageFault <= next_underVoltageFault;
      overVoltageFault <= next_overVoltageFault;
      thermalFault <= next_thermalFault;
      retryLocked <= next_retryLocked;
    end
  end
endmodule // hot_swap_fault_supervisor
`default_nettype wire

// *** rtl/hsfs_defs.svh ***
`ifndef HSFS_DEFS_SVH
`define HSFS_DEFS_SVH

// ==========================================================
// Timing figures as printed and derived cycle counts
`define HSFS_CLK_MHZ 100
`define HSFS_SUPPLY_FILT_US 1000
`define HSFS_SUPPLY_FILT_CYC (`HSFS_SUPPLY_FILT_US * `HSFS_CLK_MHZ)
`define HSFS_THERM_FILT_US 12
`define HSFS_THERM_FILT_CYC (`HSFS_THERM_FILT_US * `HSFS_CLK_MHZ)
`define HSFS_START_MS 200
`define HSFS_START_CYC (`HSFS_START_MS * 1000 * `HSFS_CLK_MHZ)
`define HSFS_PGOOD_MS 20
`define HSFS_PGOOD_CYC (`HSFS_PGOOD_MS * 1000 * `HSFS_CLK_MHZ)
`define HSFS_RETRY_LIMIT 10

// ==========================================================
// Reset values
`define HSFS_CNT_RST 32'h0000_0000
`define HSFS_RETRY_RST 4'h0

`endif

// *** rtl/hsfs_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
// Persistence filter: output follows input only after it has held for more than LIMIT cycles
module hsfs_filter #(
  parameter int unsigned LIMIT = 100000,
  parameter logic INIT = 1'b0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic level,
  output logic qualified
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic next_qualified;

  always_comb begin
    next_count = 32'h0000_0000;
    next_qualified = qualified;
    if (level != qualified) begin
      // Any return to the settled level restarts the count from zero
      next_count = count + 32'h0000_0001;
      if (count >= LIMIT) begin
        next_qualified = level;
        next_count = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count <= 32'h0000_0000;
      qualified <= INIT;
    end else begin
      count <= next_count;
      qualified <= next_qualified;
    end
  end
endmodule // hsfs_filter
`default_nettype wire

// *** rtl/hsfs_pkg.sv ***
package hsfs_pkg;
  typedef enum logic [2:0] {
    HSFS_IDLE = 3'b000,
    HSFS_START = 3'b001,
    HSFS_CHARGE = 3'b010,
    HSFS_PGWAIT = 3'b011,
    HSFS_NORMAL = 3'b100,
    HSFS_FAULT = 3'b101,
    HSFS_LOCKED = 3'b110
  } hsfs_state_e;
endpackage

// *** rtl/hsfs_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; a change is accepted when stages two and three agree
module hsfs_sync (
  input wire logic clock,
  input wire logic reset,
  input wire logic rawIn,
  output logic syncOut
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_syncOut;

  always_comb begin
    next_stage = {stage[1:0], rawIn};
    next_syncOut = (stage[2] == stage[1]) ? stage[2] : syncOut;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      stage <= 3'h0;
      syncOut <= 1'b0;
    end else begin
      stage <= next_stage;
      syncOut <= next_syncOut;
    end
  end
endmodule // hsfs_sync
`default_nettype wire

// *** sim/hsfs_load_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pass device and load: full enhancement some cycles after the gate turns on
module hsfs_load_model #(
  parameter int RAMP = 5
) (
  input wire logic clock,
  input wire logic gateEnable,
  output logic fullyEnhanced
);
  int ramp = 0;
  always @(posedge clock) begin
    ramp <= gateEnable ? ramp + 1 : 0;
  end
  // Drops at once with the gate, as a real device would
  assign fullyEnhanced = gateEnable && (ramp >= RAMP);
endmodule // hsfs_load_model
`default_nettype wire

// *** sim/hsfs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module hsfs_properties #(
  parameter int unsigned SUPPLY_FILT_CYC = 20,
  parameter int unsigned THERM_FILT_CYC = 4,
  parameter int unsigned START_CYC = 50,
  parameter int unsigned PGOOD_CYC = 30
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic underVoltageRaw,
  input wire logic overTempRaw,
  input wire logic gateEnable,
  input wire logic power_good_active_high,
  input wire logic powerGood_n,
  input wire logic underVoltageFault,
  input wire logic overVoltageFault,
  input wire logic thermalFault,
  input wire logic retryLocked
);
  // ==========================================
  // Helper counters
  // Clear time counts from any visible fault, so it can only overestimate the real timer
  logic [31:0] clearCnt, next_clearCnt, gateCnt, next_gateCnt;
  logic anyFault;
  assign anyFault = underVoltageFault || overVoltageFault || thermalFault;
  always_comb begin
    next_clearCnt = (anyFault || gateEnable) ? 32'h0000_0000 : clearCnt + 32'h0000_0001;
    next_gateCnt = gateEnable ? gateCnt + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge clock) begin
    clearCnt <= reset ? 32'h0000_0000 : next_clearCnt;
    gateCnt <= reset ? 32'h0000_0000 : next_gateCnt;
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_pg_complement: assert property (powerGood_n != power_good_active_high)
    else $error("power good outputs not complementary");
  a_pg_needs_gate: assert property (power_good_active_high |-> gateEnable)
    else $error("power good without gate");
  a_uv_gate_off: assert property (underVoltageFault |-> ##[0:2] (!gateEnable && powerGood_n))
    else $error("gate on during undervoltage");
  a_ov_gate_off: assert property (overVoltageFault |-> ##[0:2] (!gateEnable && powerGood_n))
    else $error("gate on during overvoltage");
  a_therm_gate_off: assert property (thermalFault |-> ##[0:2] !gateEnable && powerGood_n)
    else $error("gate on during thermal fault");
  a_start_wait: assert property ($rose(gateEnable) |-> clearCnt >= START_CYC)
    else $error("gate on before start time");
  a_pg_delay: assert property ($rose(power_good_active_high) |-> gateCnt > PGOOD_CYC)
    else $error("power good too early");
  a_uv_persist: assert property ($rose(underVoltageFault) |->
    $past(underVoltageRaw, 4) && $past(underVoltageRaw, SUPPLY_FILT_CYC))
    else $error("undervoltage flagged too early");
  a_therm_persist: assert property ($rose(thermalFault) |->
    $past(overTempRaw, THERM_FILT_CYC))
    else $error("thermal flagged too early");
  a_lock_off: assert property (retryLocked |-> !gateEnable)
    else $error("gate on while locked");
endmodule // hsfs_properties
bind hot_swap_fault_supervisor hsfs_properties #(.SUPPLY_FILT_CYC(SUPPLY_FILT_CYC),
  .THERM_FILT_CYC(THERM_FILT_CYC), .START_CYC(START_CYC), .PGOOD_CYC(PGOOD_CYC)) chk_u (
  .clock(clock), .reset(reset), .underVoltageRaw(underVoltageRaw), .overTempRaw(overTempRaw),
  .gateEnable(gateEnable), .power_good_active_high(power_good_active_high),
  .powerGood_n(powerGood_n), .underVoltageFault(underVoltageFault),
  .overVoltageFault(overVoltageFault), .thermalFault(thermalFault),
  .retryLocked(retryLocked));
`default_nettype wire

// *** sim/tb_hot_swap_fault_supervisor.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin nFail++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_hot_swap_fault_supervisor;
  import hsfs_pkg::*;
  localparam int START = 50;
  logic clock = 0, reset = 1, uvRaw = 0, ovRaw = 0, otRaw = 0, recRaw = 1, disRaw = 0;
  logic fullyEnhanced, gate, pg, pgN, uvF, ovF, thF, locked;
  logic [3:0] retryCount;
  int nFail = 0, testsRun = 0, cycles = 0, n;
  always #5 clock = ~clock;
  hot_swap_fault_supervisor #(.SUPPLY_FILT_CYC(20), .THERM_FILT_CYC(4), .START_CYC(START),
    .PGOOD_CYC(30), .RETRY_LIMIT(10)) dut_u (.clock(clock), .reset(reset),
    .underVoltageRaw(uvRaw), .overVoltageRaw(ovRaw), .overTempRaw(otRaw),
    .tempRecoveredRaw(recRaw), .disableRaw(disRaw), .fullyEnhanced(fullyEnhanced),
    .gateEnable(gate), .power_good_active_high(pg), .powerGood_n(pgN),
    .underVoltageFault(uvF), .overVoltageFault(ovF), .thermalFault(thF),
    .retryLocked(locked), .retryCount(retryCount));
  hsfs_load_model load_u (.clock(clock), .gateEnable(gate), .fullyEnhanced(fullyEnhanced));
  // ==========================================
  // Tasks
  task automatic step(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic waitHigh(input int sel, output int c);
    c = 0;
    while ((sel ? pg : gate) !== 1'b1 && c < 1000) begin
      step(1);
      c++;
    end
    `CHK("waitHigh", 1'b1, c < 1000)
  endtask
  task automatic setRaw(input int k, input logic v);
    if (k == 0) uvRaw = v;
    else ovRaw = v;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      nFail++;
      summarize();
    end
  end
  // ==========================================
  // Sequence
  initial begin
    step(2);
    reset = 0;
    `CHK("gateRst", 1'b0, gate)
    `CHK("pgNRst", 1'b1, pgN)
    waitHigh(0, n);
    `CHK("startTime", 1'b1, n >= START)
    waitHigh(1, n);
    `CHK("pgN", 1'b0, pgN)
    for (int k = 0; k < 2; k++) begin
      setRaw(k, 1);
      step(10);
      setRaw(k, 0);
      step(30);
      `CHK("glitch", 1'b0, k ? ovF : uvF)
      setRaw(k, 1);
      step(40);
      `CHK("fault", 1'b1, k ? ovF : uvF)
      `CHK("gateOff", 1'b0, gate)
      `CHK("pgOff", 1'b0, pg)
      setRaw(k, 0);
      step(30);
      `CHK("clearFlag", 1'b0, k ? ovF : uvF)
      setRaw(k, 1);
      step(40);
      setRaw(k, 0);
      step(30);
      `CHK("abandon", 1'b0, gate)
      waitHigh(0, n);
      `CHK("restart", 1'b1, n >= START - 30)
      waitHigh(1, n);
    end
    otRaw = 1;
    step(3);
    otRaw = 0;
    step(15);
    `CHK("thermGlitch", 1'b0, thF)
    otRaw = 1;
    recRaw = 0;
    step(15);
    `CHK("thermFault", 1'b1, thF)
    `CHK("thermGate", 1'b0, gate)
    otRaw = 0;
    step(200);
    `CHK("noRecovery", 1'b0, gate)
    recRaw = 1;
    waitHigh(0, n);
    `CHK("retryOne", 4'h1, retryCount)
    waitHigh(1, n);
    `CHK("retryClr", 4'h0, retryCount)
    // Eleven counted aborts take the count past the limit of ten
    repeat (11) begin
      disRaw = 1;
      step(30);
      disRaw = 0;
      step(30);
    end
    `CHK("locked", 1'b1, locked)
    `CHK("lockCount", 4'hb, retryCount)
    step(200);
    `CHK("lockedGate", 1'b0, gate)
    `CHK("lockHeld", 1'b1, locked)
    disRaw = 1;
    step(30);
    disRaw = 0;
    step(30);
    `CHK("unlocked", 1'b0, locked)
    `CHK("unlockCount", 4'h0, retryCount)
    waitHigh(0, n);
    `CHK("unlockStart", 1'b1, n >= START - 10)
    summarize();
  end
endmodule // tb_hot_swap_fault_supervisor
`default_nettype wire
